/* File: src/pfs_sequencer.sv */
`timescale 1ns/1ps
// What this block does
// - lift cassette at power-up and on insertion
// - run lifter until stack sensor sees rack
// - flag lifter failure on lift timeout
// - print command starts pickup motor
// - cassette solenoid fires at programmed delay
// - manual tray solenoid fires in the same cycle as motor start
// - decode seven sizes, end switches off
// - width 101 plus bottom end gives A4-R
// - both ends on give A3/11x17/B4/Legal
// - top end switch on means cassette absent
// - report cassette out of paper
// - watch manual tray media presence
// - last-paper sensor reports manual media absence
// - leading edge triggers pickup speed alignment
// - flag sheet length mismatch
module pfs_sequencer
	import pfs_pkg::*;
(
	// clock and reset
	input  wire logic   ref_clk,
	input  wire logic   rst,
	// paper path pins
	input  pfs_sensor_s sensor,
	// formatter commands
	input  wire logic   print_cmd,
	input  pfs_src_e    print_src,
	input  pfs_cfg_s    cfg,
	// actuators
	output logic        lifter_motor_ff,
	output logic        pickup_motor_ff,
	output logic        pickup_align_ff,
	output logic        cassette_sol_ff,
	output logic        manual_sol_ff,
	// formatter status
	output pfs_status_s status
);
	typedef enum logic [2:0] {P_IDLE, P_CST_WAIT, P_SOL, P_FEED, P_MEASURE} pfs_pick_e;

	pfs_sensor_s      s_sync;
	pfs_pick_e        pick_ff;
	pfs_src_e         src_ff;
	logic             lift_req_ff;
	logic             lift_fail_ff;
	logic             absent_ff;
	logic             empty_ff;
	logic             man_present_ff;
	logic             man_absent_ff;
	logic             mismatch_ff;
	logic             done_ff;
	logic             busy_ff;
	logic             edge_prev_ff;
	pfs_size_e        size_ff;
	logic [CNT_W-1:0] lift_cnt_ff;
	logic [CNT_W-1:0] pick_cnt_ff;
	logic [CNT_W-1:0] align_cnt_ff;
	logic [LEN_W-1:0] len_cnt_ff;
	logic             edge_rise;
	logic             edge_fall;
	logic             start_ok;
	logic [LEN_W-1:0] len_diff;

	// all pins pass two flops
	pfs_sync #(.W($bits(pfs_sensor_s))) u_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.din     (sensor),
		.dout    (s_sync)
	);

	assign edge_rise = s_sync.leading_edge & ~edge_prev_ff;
	assign edge_fall = ~s_sync.leading_edge & edge_prev_ff;
	assign len_diff  = (len_cnt_ff > cfg.req_length) ? len_cnt_ff - cfg.req_length
	                                                 : cfg.req_length - len_cnt_ff;
	// pickup allowed only with a ready source
	assign start_ok  = (print_src == SRC_CASSETTE)
		? (~s_sync.end_top & ~s_sync.media_out & ~lifter_motor_ff & ~lift_fail_ff)
		: (s_sync.manual_media & ~man_absent_ff);

	// edge history for the leading edge sensor
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			edge_prev_ff <= 1'b0;
		else
			edge_prev_ff <= s_sync.leading_edge;
	end

	// lift request: power-up and cassette insertion
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			lift_req_ff <= 1'b1;
			absent_ff   <= 1'b0;
		end
		else
		begin
			absent_ff <= s_sync.end_top;
			if (absent_ff & ~s_sync.end_top)
				lift_req_ff <= 1'b1;
			else if (lifter_motor_ff | s_sync.end_top)
				lift_req_ff <= 1'b0;
		end
	end

	// lifter motor and failure timer
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			lifter_motor_ff <= 1'b0;
			lift_fail_ff    <= 1'b0;
			lift_cnt_ff     <= CNT_ZERO;
		end
		else if (lifter_motor_ff)
		begin
			lift_cnt_ff <= lift_cnt_ff + CNT_ONE;
			if (s_sync.stack_surface | s_sync.end_top)
				lifter_motor_ff <= 1'b0;
			else if (lift_cnt_ff >= cfg.lift_timeout)
			begin
				lifter_motor_ff <= 1'b0;
				lift_fail_ff    <= 1'b1;
			end
		end
		else if (lift_req_ff & ~s_sync.end_top & pick_ff == P_IDLE)
		begin
			lifter_motor_ff <= ~s_sync.stack_surface;
			lift_fail_ff    <= 1'b0;
			lift_cnt_ff     <= CNT_ZERO;
		end
	end

	// media presence flags
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			empty_ff       <= 1'b0;
			man_present_ff <= 1'b0;
			man_absent_ff  <= 1'b0;
			size_ff        <= SZ_UNKNOWN;
		end
		else
		begin
			empty_ff       <= s_sync.media_out & ~s_sync.end_top;
			man_present_ff <= s_sync.manual_media;
			size_ff        <= pfs_decode(s_sync.width_sw,
				{s_sync.end_center, s_sync.end_bottom});
			if (s_sync.last_paper & src_ff == SRC_MANUAL & pick_ff != P_IDLE)
				man_absent_ff <= 1'b1;
			else if (~s_sync.last_paper & ~s_sync.manual_media)
				man_absent_ff <= 1'b0; // tray emptied, wait for reload
			else if (~s_sync.last_paper & pick_ff == P_IDLE & ~man_present_ff
				& s_sync.manual_media)
				man_absent_ff <= 1'b0; // reloaded
		end
	end

	// pickup and feed sequence
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pick_ff         <= P_IDLE;
			src_ff          <= SRC_CASSETTE;
			pickup_motor_ff <= 1'b0;
			cassette_sol_ff <= 1'b0;
			manual_sol_ff   <= 1'b0;
			pick_cnt_ff     <= CNT_ZERO;
			len_cnt_ff      <= LEN_ZERO;
			mismatch_ff     <= 1'b0;
			done_ff         <= 1'b0;
			busy_ff         <= 1'b0;
		end
		else
		begin
			done_ff <= 1'b0;
			unique case (pick_ff)
				P_IDLE:
				begin
					if (print_cmd & start_ok & ~lifter_motor_ff)
					begin
						pickup_motor_ff <= 1'b1;
						busy_ff         <= 1'b1;
						src_ff          <= print_src;
						pick_cnt_ff     <= CNT_ZERO;
						mismatch_ff     <= 1'b0;
						if (print_src == SRC_CASSETTE)
							pick_ff <= P_CST_WAIT;
						else
						begin
							manual_sol_ff <= 1'b1;
							pick_ff       <= P_SOL;
						end
					end
				end
				P_CST_WAIT:
				begin
					pick_cnt_ff <= pick_cnt_ff + CNT_ONE;
					if (pick_cnt_ff >= cfg.sol_delay)
					begin
						cassette_sol_ff <= 1'b1;
						pick_cnt_ff     <= CNT_ZERO;
						pick_ff         <= P_SOL;
					end
				end
				P_SOL:
				begin
					pick_cnt_ff <= pick_cnt_ff + CNT_ONE;
					if (pick_cnt_ff >= cfg.sol_on)
					begin
						cassette_sol_ff <= 1'b0;
						manual_sol_ff   <= 1'b0;
						pick_ff         <= P_FEED;
					end
				end
				P_FEED:
				begin
					// the rise cycle is the sheet's first cycle
					len_cnt_ff <= edge_rise ? LEN_ONE : LEN_ZERO;
					if (edge_rise)
						pick_ff <= P_MEASURE;
				end
				P_MEASURE:
				begin
					len_cnt_ff <= len_cnt_ff + LEN_ONE;
					if (edge_fall)
					begin
						mismatch_ff     <= (len_diff > cfg.len_tol);
						pickup_motor_ff <= 1'b0;
						busy_ff         <= 1'b0;
						done_ff         <= 1'b1;
						pick_ff         <= P_IDLE;
					end
				end
			endcase
		end
	end

	// speed alignment window after the leading edge
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pickup_align_ff <= 1'b0;
			align_cnt_ff    <= CNT_ZERO;
		end
		else if (pick_ff == P_FEED & edge_rise)
		begin
			pickup_align_ff <= 1'b1;
			align_cnt_ff    <= CNT_ZERO;
		end
		else if (pickup_align_ff)
		begin
			align_cnt_ff <= align_cnt_ff + CNT_ONE;
			if (align_cnt_ff >= cfg.align_time | pick_ff == P_IDLE)
				pickup_align_ff <= 1'b0;
		end
	end

	// status bits, all from flops
	assign status = '{lift_fail: lift_fail_ff, cassette_absent: absent_ff,
		cassette_empty: empty_ff, manual_present: man_present_ff,
		manual_absent: man_absent_ff, size_mismatch: mismatch_ff,
		busy: busy_ff, feed_done: done_ff, size: size_ff};

	// checks
	property p_lift_stop;
		@(posedge ref_clk) disable iff (rst)
		lifter_motor_ff & s_sync.stack_surface |=> ~lifter_motor_ff;
	endproperty
	a_lift_stop: assert property (p_lift_stop) else $error("lifter ran past stack");

	property p_lift_fail;
		@(posedge ref_clk) disable iff (rst)
		$rose(lift_fail_ff) |-> $past(lifter_motor_ff) & ~lifter_motor_ff;
	endproperty
	a_lift_fail: assert property (p_lift_fail) else $error("fail without timeout");

	property p_power_lift;
		@(posedge ref_clk) disable iff (rst)
		~rst & lift_req_ff & ~s_sync.end_top & ~s_sync.stack_surface & pick_ff == P_IDLE
			& ~lifter_motor_ff |=> lifter_motor_ff;
	endproperty
	a_power_lift: assert property (p_power_lift) else $error("lift not started");

	property p_pick_start;
		@(posedge ref_clk) disable iff (rst)
		pick_ff == P_IDLE & print_cmd & start_ok & ~lifter_motor_ff
			|=> pickup_motor_ff & pick_ff != P_IDLE;
	endproperty
	a_pick_start: assert property (p_pick_start) else $error("motor not started");

	property p_cst_sol;
		@(posedge ref_clk) disable iff (rst)
		$rose(cassette_sol_ff) |-> pickup_motor_ff & src_ff == SRC_CASSETTE
			& $past(pick_ff) == P_CST_WAIT;
	endproperty
	a_cst_sol: assert property (p_cst_sol) else $error("cassette solenoid early");

	property p_man_sol;
		@(posedge ref_clk) disable iff (rst)
		$rose(manual_sol_ff) |-> $rose(pickup_motor_ff) & src_ff == SRC_MANUAL;
	endproperty
	a_man_sol: assert property (p_man_sol) else $error("manual solenoid wrong");

	property p_size;
		@(posedge ref_clk) disable iff (rst)
		~rst |=> size_ff == pfs_decode($past(s_sync.width_sw),
			{$past(s_sync.end_center), $past(s_sync.end_bottom)});
	endproperty
	a_size: assert property (p_size) else $error("size decode stale");

	property p_absent;
		@(posedge ref_clk) disable iff (rst)
		s_sync.end_top |=> status.cassette_absent;
	endproperty
	a_absent: assert property (p_absent) else $error("absence not shown");

	property p_empty;
		@(posedge ref_clk) disable iff (rst)
		s_sync.media_out & ~s_sync.end_top |=> status.cassette_empty;
	endproperty
	a_empty: assert property (p_empty) else $error("empty not shown");

	property p_last;
		@(posedge ref_clk) disable iff (rst)
		s_sync.last_paper & src_ff == SRC_MANUAL & pick_ff != P_IDLE |=> man_absent_ff;
	endproperty
	a_last: assert property (p_last) else $error("last sheet missed");

	property p_align;
		@(posedge ref_clk) disable iff (rst)
		pick_ff == P_FEED & edge_rise |=> pickup_align_ff ##1 pickup_motor_ff;
	endproperty
	a_align: assert property (p_align) else $error("no alignment");

	property p_mismatch;
		@(posedge ref_clk) disable iff (rst)
		$rose(mismatch_ff) |-> done_ff & $past(pick_ff) == P_MEASURE;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatch off-sheet");

	c_cst_feed: cover property (@(posedge ref_clk) disable iff (rst)
		$rose(cassette_sol_ff) ##[1:1000] done_ff);
	c_man_feed: cover property (@(posedge ref_clk) disable iff (rst)
		$rose(manual_sol_ff) ##[1:1000] done_ff);
	c_lift_fail: cover property (@(posedge ref_clk) disable iff (rst) $rose(lift_fail_ff));
	c_mismatch: cover property (@(posedge ref_clk) disable iff (rst) $rose(mismatch_ff));
endmodule

/* File: src/pfs_pkg.sv */
package pfs_pkg;

	// widths of the programmable counts
	localparam int CNT_W = 24;
	localparam int LEN_W = 20;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;
	localparam logic [LEN_W-1:0] LEN_ZERO = 20'h00000;
	localparam logic [LEN_W-1:0] LEN_ONE  = 20'h00001;

	// width switch codes, top/center/bottom
	localparam logic [2:0] W_111 = 3'h7;
	localparam logic [2:0] W_110 = 3'h6;
	localparam logic [2:0] W_100 = 3'h4;
	localparam logic [2:0] W_000 = 3'h0;
	localparam logic [2:0] W_011 = 3'h3;
	localparam logic [2:0] W_001 = 3'h1;
	localparam logic [2:0] W_101 = 3'h5;

	// end switch codes, center/bottom
	localparam logic [1:0] E_NONE   = 2'h0;
	localparam logic [1:0] E_BOTTOM = 2'h1;
	localparam logic [1:0] E_BOTH   = 2'h3;

	typedef enum logic [3:0] {
		SZ_UNKNOWN, SZ_A4, SZ_LETTER, SZ_B5, SZ_EXEC, SZ_A5R, SZ_B5R,
		SZ_LETTER_R, SZ_A4R, SZ_A3, SZ_11X17, SZ_B4, SZ_LEGAL
	} pfs_size_e;

	typedef enum logic {SRC_CASSETTE, SRC_MANUAL} pfs_src_e;

	// raw sensor and switch levels from the paper path
	typedef struct packed {
		logic [2:0] width_sw;       // top, center, bottom; 1 = on
		logic       end_top;        // on = cassette absent
		logic       end_center;
		logic       end_bottom;
		logic       stack_surface;  // 1 = lifter rack seen
		logic       media_out;      // 1 = cassette empty
		logic       manual_media;   // 1 = paper on manual feed tray
		logic       last_paper;     // 1 = final manual sheet picked
		logic       leading_edge;   // 1 = sheet under edge sensor
	} pfs_sensor_s;

	// programmable figures from the formatter
	typedef struct packed {
		logic [CNT_W-1:0] lift_timeout;
		logic [CNT_W-1:0] sol_delay;
		logic [CNT_W-1:0] sol_on;
		logic [CNT_W-1:0] align_time;
		logic [LEN_W-1:0] req_length;
		logic [LEN_W-1:0] len_tol;
	} pfs_cfg_s;

	// status back to the formatter
	typedef struct packed {
		logic      lift_fail;
		logic      cassette_absent;
		logic      cassette_empty;
		logic      manual_present;
		logic      manual_absent;
		logic      size_mismatch;
		logic      busy;
		logic      feed_done;
		pfs_size_e size;
	} pfs_status_s;

	// cassette size from width and end switches
	function automatic pfs_size_e pfs_decode(input logic [2:0] w, input logic [1:0] e);
		pfs_size_e s;
		s = SZ_UNKNOWN;
		if (e == E_NONE)
		begin
			case (w)
				W_111: s = SZ_A4;
				W_110: s = SZ_LETTER;
				W_100: s = SZ_B5;
				W_000: s = SZ_EXEC;
				W_011: s = SZ_A5R;
				W_001: s = SZ_B5R;
				W_101: s = SZ_LETTER_R;
				default: s = SZ_UNKNOWN;
			endcase
		end
		else if (e == E_BOTTOM && w == W_101)
			s = SZ_A4R;
		else if (e == E_BOTH)
		begin
			case (w)
				W_111: s = SZ_A3;
				W_110: s = SZ_11X17;
				W_100: s = SZ_B4;
				W_101: s = SZ_LEGAL;
				default: s = SZ_UNKNOWN;
			endcase
		end
		return s;
	endfunction

endpackage

/* File: src/pfs_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module pfs_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_ff;

	// first stage feeds only the second
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			meta_ff <= '0;
			dout    <= '0;
		end
		else
		begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end
endmodule

/* File: tb/pfs_fmt_model.sv */
`timescale 1ns/1ps
// formatter side: turns a bench request into a one-cycle print command
module pfs_fmt_model
	import pfs_pkg::*;
(
	// clock and reset
	input  wire logic   ref_clk,
	input  wire logic   rst,
	// bench request
	input  wire logic   go,
	input  pfs_src_e    go_src,
	// engine side
	input  pfs_status_s status,
	output logic        print_cmd,
	output pfs_src_e    print_src
);
	// one pulse per request while idle; source shows junk between commands
	always_ff @(posedge ref_clk)
	begin
		print_cmd <= go & ~rst & ~status.busy;
		print_src <= go ? go_src : pfs_src_e'(~print_src);
	end
endmodule

/* File: tb/test_paper_pickup_feed_sequencer.sv */
`timescale 1ns/1ps
// self-checking bench for the pickup and feed sequencer
module test_paper_pickup_feed_sequencer
	import pfs_pkg::*;
;
	localparam int SOL_DLY = 4;
	localparam int SOL_ON  = 3;
	localparam int ALIGN   = 5;
	localparam int REQ     = 40;
	localparam int TOL     = 2;
	localparam int LIFT_TO = 30;
	// bench signals
	logic        ref_clk;
	logic        rst;
	logic        go;
	pfs_src_e    go_src;
	pfs_sensor_s sens;
	pfs_cfg_s    cfg;
	logic        print_cmd;
	pfs_src_e    print_src;
	logic        lift_m;
	logic        pick_m;
	logic        align;
	logic        cas_sol;
	logic        man_sol;
	pfs_status_s status;
	int          n_errors;
	int          check_count;
	logic [31:0] xs_state;
	int          n;

	pfs_fmt_model fmt_u (.ref_clk(ref_clk), .rst(rst), .go(go), .go_src(go_src),
		.status(status), .print_cmd(print_cmd), .print_src(print_src));
	pfs_sequencer dut_u (.ref_clk(ref_clk), .rst(rst), .sensor(sens), .print_cmd(print_cmd),
		.print_src(print_src), .cfg(cfg), .lifter_motor_ff(lift_m), .pickup_motor_ff(pick_m),
		.pickup_align_ff(align), .cassette_sol_ff(cas_sol), .manual_sol_ff(man_sol),
		.status(status));

	// 40 MHz clock
	initial ref_clk = 1'b0;
	always #12.5 ref_clk = ~ref_clk;

	// xorshift source of sheet lengths
	function automatic logic [31:0] xs();
		xs_state ^= xs_state << 13;
		xs_state ^= xs_state >> 17;
		xs_state ^= xs_state << 5;
		return xs_state;
	endfunction

	// expected size from switch index: width in bits 4:2, center/bottom end in 1:0
	function automatic pfs_size_e exp_size(input int i);
		int w;
		int e;
		w = i / 4;
		e = i % 4;
		if (e == 0)
			case (w)
				7: return SZ_A4;
				6: return SZ_LETTER;
				4: return SZ_B5;
				0: return SZ_EXEC;
				3: return SZ_A5R;
				1: return SZ_B5R;
				5: return SZ_LETTER_R;
				default: return SZ_UNKNOWN;
			endcase
		if (e == 1 && w == 5)
			return SZ_A4R;
		if (e == 3)
			case (w)
				7: return SZ_A3;
				6: return SZ_11X17;
				4: return SZ_B4;
				5: return SZ_LEGAL;
				default: return SZ_UNKNOWN;
			endcase
		return SZ_UNKNOWN;
	endfunction

	// output selected by index for bounded waits
	function automatic logic pick(input int k);
		case (k)
			0: return lift_m;
			1: return pick_m;
			2: return align;
			3: return cas_sol;
			4: return man_sol;
			5: return status.feed_done;
			6: return status.lift_fail;
			default: return status.cassette_absent;
		endcase
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// counts falling edges until the output takes the level; gives up once the count passes lim
	task automatic wait_for(input int k, input logic v, input int lim, output int cnt);
		cnt = 0;
		while (pick(k) !== v)
		begin
			@(negedge ref_clk);
			cnt++;
			if (cnt > lim)
			begin
				n_errors++;
				$display("CHECK FAILED wait_%0d expected %0b seen timeout", k, v);
				tally_and_finish();
			end
		end
	endtask

	task automatic request(input pfs_src_e s);
		@(posedge ref_clk);
		go <= 1'b1;
		go_src <= s;
		@(posedge ref_clk);
		go <= 1'b0;
		go_src <= pfs_src_e'(~s);
		@(negedge ref_clk);
	endtask

	// pull and reinsert the cassette with the stack sensor dark
	task automatic relift();
		int c;
		@(posedge ref_clk);
		sens.end_top <= 1'b1;
		sens.stack_surface <= 1'b0;
		wait_for(7, 1'b1, 6, c);
		@(posedge ref_clk);
		sens.end_top <= 1'b0;
		wait_for(0, 1'b1, 8, c);
	endtask

	// one sheet: solenoid timing, edge alignment, length verdict
	task automatic feed(input pfs_src_e s, input int len);
		int c;
		int k;
		logic mm;
		mm = ((len > REQ) ? len - REQ : REQ - len) > TOL;
		k = (s == SRC_CASSETTE) ? 3 : 4;
		request(s);
		wait_for(1, 1'b1, 4, c);
		check("busy_on", status.busy, 1'b1);
		wait_for(k, 1'b1, SOL_DLY + 4, c);
		check("sol_delay", c, (s == SRC_CASSETTE) ? SOL_DLY + 1 : 0);
		wait_for(k, 1'b0, SOL_ON + 4, c);
		check("sol_width", c, SOL_ON + 1);
		@(posedge ref_clk);
		sens.last_paper <= (s == SRC_MANUAL);
		sens.leading_edge <= 1'b1;
		fork
			begin
				repeat (len) @(posedge ref_clk);
				sens.leading_edge <= 1'b0;
			end
			begin
				wait_for(2, 1'b1, 6, c);
				wait_for(2, 1'b0, ALIGN + 4, c);
				check("align_width", c, ALIGN + 1);
			end
		join
		wait_for(5, 1'b1, 8, c);
		check("size_mismatch", status.size_mismatch, mm);
		check("motor_stop", pick_m, 1'b0);
		check("busy_off", status.busy, 1'b0);
		$display("test feed %0d done", len);
	endtask

	// main sequence
	initial
	begin
		rst = 1'b1;
		go = 1'b0;
		go_src = SRC_CASSETTE;
		sens = '0;
		cfg.lift_timeout = CNT_W'(LIFT_TO);
		cfg.sol_delay = CNT_W'(SOL_DLY);
		cfg.sol_on = CNT_W'(SOL_ON);
		cfg.align_time = CNT_W'(ALIGN);
		cfg.req_length = LEN_W'(REQ);
		cfg.len_tol = LEN_W'(TOL);
		n_errors = 0;
		check_count = 0;
		xs_state = 32'h0000FC17;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		check("lifter_in_reset", lift_m, 1'b0);
		check("size_in_reset", status.size, SZ_UNKNOWN);
		@(posedge ref_clk);
		rst <= 1'b0;
		wait_for(0, 1'b1, 8, n);
		@(posedge ref_clk);
		sens.stack_surface <= 1'b1;
		wait_for(0, 1'b0, 6, n);
		check("lift_stop", n <= 4, 1'b1);
		$display("test lift done");
		relift();
		wait_for(6, 1'b1, LIFT_TO + 8, n);
		check("lifter_at_fail", lift_m, 1'b0);
		relift();
		check("lift_fail_cleared", status.lift_fail, 1'b0);
		@(posedge ref_clk);
		sens.stack_surface <= 1'b1;
		wait_for(0, 1'b0, 6, n);
		$display("test lift fail done");
		for (int i = 0; i < 32; i++)
		begin
			@(posedge ref_clk);
			sens.width_sw <= i[4:2];
			sens.end_center <= i[1];
			sens.end_bottom <= i[0];
			repeat (5) @(negedge ref_clk);
			check("size", status.size, exp_size(i));
		end
		$display("test size decode done");
		@(posedge ref_clk);
		sens.media_out <= 1'b1;
		repeat (4) @(negedge ref_clk);
		check("cassette_empty", status.cassette_empty, 1'b1);
		request(SRC_CASSETTE);
		repeat (6) @(negedge ref_clk);
		check("empty_refused", pick_m, 1'b0);
		@(posedge ref_clk);
		sens.media_out <= 1'b0;
		repeat (4) @(negedge ref_clk);
		$display("test empty done");
		feed(SRC_CASSETTE, REQ + TOL);
		feed(SRC_CASSETTE, REQ + TOL + 1);
		feed(SRC_CASSETTE, REQ - TOL - 1);
		repeat (3) feed(SRC_CASSETTE, 30 + int'(xs() % 21));
		@(posedge ref_clk);
		sens.manual_media <= 1'b1;
		repeat (4) @(negedge ref_clk);
		check("manual_present", status.manual_present, 1'b1);
		feed(SRC_MANUAL, REQ);
		check("manual_absent", status.manual_absent, 1'b1);
		request(SRC_MANUAL);
		repeat (6) @(negedge ref_clk);
		check("last_sheet_refused", pick_m, 1'b0);
		$display("test manual done");
		tally_and_finish();
	end
endmodule
